/* File: tpo_defs.svh */
`ifndef TPO_DEFS_SVH
`define TPO_DEFS_SVH

// Widths of the pattern unit
`define TPO_NBITS      12
`define TPO_GRP_W      4
`define TPO_NGRP       3
`define TPO_NCH        4
`define TPO_SEL_W      2

// Field positions inside the packed configuration fields
`define TPO_SEL_POS(g) ((g) * 2)
`define TPO_NOV_POS(g) (g)
`define TPO_GRP_POS(g) ((g) * 4)

// Reset values
`define TPO_SEL_RST    6'h3F
`define TPO_NOV_RST    3'h0
`define TPO_DIR_RST    12'h000
`define TPO_EN_RST     12'h000
`define TPO_PORT_RST   12'h000
`define TPO_STG_RST    12'h000
`define TPO_RD_RST     12'h000

`endif

/* File: tpo_pkg.sv */
`include "tpo_defs.svh"

package tpo_pkg;

    // Pin function, coded as {next_enable_bit, port direction bit}
    typedef enum logic [1:0] {
        TPO_FN_INPUT     = 2'b00,
        TPO_FN_OUTPUT    = 2'b01,
        TPO_FN_LOCKED_IN = 2'b10,
        TPO_FN_PATTERN   = 2'b11
    } tpo_pin_fn_e;

    // Software configuration of the unit
    typedef struct packed {
        logic [`TPO_NBITS-1:0]            port_direction;
        logic [`TPO_NBITS-1:0]            next_enable;
        logic [`TPO_NGRP*`TPO_SEL_W-1:0]  trigger_select;
        logic [`TPO_NGRP-1:0]             nonoverlap;
    } tpo_cfg_s;

    // Per-channel events and modes from the integrated timer unit
    typedef struct packed {
        logic [`TPO_NCH-1:0] cmp_a;
        logic [`TPO_NCH-1:0] cmp_b;
        logic [`TPO_NCH-1:0] capt_a;
        logic [`TPO_NCH-1:0] capt_mode;
    } tpo_evt_s;

endpackage

/* File: tpo_group.sv */
`timescale 1ns/1ps

// Next value of one four-bit group of port data bits
module tpo_group (
    // Current and staged data
    input  wire logic [3:0] cur,
    input  wire logic [3:0] staged,
    // Trigger events of the selected channel
    input  wire logic       ev_a,
    input  wire logic       ev_b,
    input  wire logic       nov,
    // Software write of port data
    input  wire logic       wr,
    input  wire logic [3:0] wdata,
    input  wire logic [3:0] wmask,
    // Result
    output logic      [3:0] nxt
);

    // Match A overrides a software write in the same cycle; match B clears bits on top of it
    always_comb begin
        nxt = cur;
        if (wr) begin
            nxt = (cur & ~wmask) | (wdata & wmask);
        end
        if (ev_a) begin
            nxt = staged;
        end else if (nov && ev_b) begin
            nxt = nxt & staged;
        end
    end

endmodule

/* File: tpo_timed_pattern.sv */
`timescale 1ns/1ps
`include "tpo_defs.svh"

// Overview of operation
// - Pattern output whenever direction is 1; next enable does not gate the copy.
// - Once enabled, the pin first shows the current port data bit.
// - On the group's trigger, staged bits are copied into port data.
// - Enable/direction 00 input; 01 and 11 both pattern output, decoded alike.
// - Enable 1, direction 0: input, port bit read-only yet still copied.
// - If register A captures, the capture event replaces compare match A.
// - A pin claimed by timer or address output is not driven here.
// - Staged bits are copied on triggers even when the pin is claimed.
// - Non-overlapping mode copies all staged bits at compare match A.
// - Non-overlapping mode copies only zero staged bits at match B.
// - Two-bit select picks timer channel 0 to 3; channel 3 after reset.
// - Non-overlap bit 0 updates at match A; 1 splits ones and zeros.
module tpo_timed_pattern (
    // Clock and reset
    input  wire logic                      clk_sys,
    input  wire logic                      rst_n,
    // Configuration write and readback
    input  wire logic                      cfg_wr,
    input  wire tpo_pkg::tpo_cfg_s         cfg_wdata,
    output tpo_pkg::tpo_cfg_s              cfg,
    // Staged data and port data writes
    input  wire logic                      staged_wr,
    input  wire logic [`TPO_NBITS-1:0]     staged_wdata,
    input  wire logic                      port_wr,
    input  wire logic [`TPO_NBITS-1:0]     port_wdata,
    // Timer events
    input  wire tpo_pkg::tpo_evt_s         timer_evt,
    // Pin sharing with timer and address output
    input  wire logic [`TPO_NBITS-1:0]     pin_claimed,
    // Pins
    input  wire logic [`TPO_NBITS-1:0]     pin_in,
    output logic      [`TPO_NBITS-1:0]     pin_out,
    output logic      [`TPO_NBITS-1:0]     pin_oe_n,
    // Readback
    output logic      [`TPO_NBITS-1:0]     staged_value,
    output logic      [`TPO_NBITS-1:0]     port_value,
    output logic      [`TPO_NBITS-1:0]     port_read
);

    tpo_pkg::tpo_cfg_s       cfg_r;
    tpo_pkg::tpo_cfg_s       cfg_nxt;
    logic                    cfg_seen_r;
    logic                    cfg_seen_nxt;
    logic [`TPO_NBITS-1:0]   stg_r;
    logic [`TPO_NBITS-1:0]   stg_nxt;
    logic [`TPO_NBITS-1:0]   port_r;
    logic [`TPO_NBITS-1:0]   port_nxt;
    logic [`TPO_NBITS-1:0]   rd_r;
    logic [`TPO_NBITS-1:0]   rd_nxt;
    logic [`TPO_NGRP-1:0]    ev_a;
    logic [`TPO_NGRP-1:0]    ev_b;
    logic [`TPO_NBITS-1:0]   wmask;
    logic [`TPO_NBITS-1:0]   drive;

    // Picks the bit of one timer channel
    function automatic logic pick(input logic [`TPO_NCH-1:0] v,
                                  input logic [1:0]          ch);
        pick = v[ch];
    endfunction

    // Trigger events per group from its selected channel
    always_comb begin
        logic [1:0] ch;
        ch = 2'h0;
        ev_a = '0;
        ev_b = '0;
        for (int g = 0; g < `TPO_NGRP; g++) begin
            ch = cfg_r.trigger_select[`TPO_SEL_POS(g) +: `TPO_SEL_W];
            if (pick(timer_evt.capt_mode, ch)) begin
                ev_a[g] = pick(timer_evt.capt_a, ch);
            end else begin
                ev_a[g] = pick(timer_evt.cmp_a, ch);
            end
            // Match B only matters in non-overlapping mode
            ev_b[g] = cfg_r.nonoverlap[`TPO_NOV_POS(g)]
                      & pick(timer_evt.cmp_b, ch);
        end
    end

    // Pin function decode, write mask and read source
    always_comb begin
        tpo_pkg::tpo_pin_fn_e fn;
        fn = tpo_pkg::TPO_FN_INPUT;
        wmask = '0;
        drive = '0;
        rd_nxt = '0;
        for (int i = 0; i < `TPO_NBITS; i++) begin
            fn = tpo_pkg::tpo_pin_fn_e'({cfg_r.next_enable[i],
                                         cfg_r.port_direction[i]});
            case (fn)
                tpo_pkg::TPO_FN_INPUT: begin
                    wmask[i] = 1'b1;
                    rd_nxt[i] = pin_in[i];
                end
                tpo_pkg::TPO_FN_OUTPUT: begin
                    wmask[i] = 1'b1;
                    drive[i] = 1'b1;
                    rd_nxt[i] = port_r[i];
                end
                tpo_pkg::TPO_FN_LOCKED_IN: begin
                    wmask[i] = 1'b0;
                    rd_nxt[i] = pin_in[i];
                end
                tpo_pkg::TPO_FN_PATTERN: begin
                    wmask[i] = 1'b1;
                    drive[i] = 1'b1;
                    rd_nxt[i] = port_r[i];
                end
                default: begin
                    wmask[i] = 1'b1;
                    rd_nxt[i] = pin_in[i];
                end
            endcase
        end
    end

    // A claimed pin is released at once, without waiting a cycle
    assign pin_oe_n = ~(drive & ~pin_claimed);
    assign pin_out  = port_r;

    // Port data next value, one group at a time
    for (genvar g = 0; g < `TPO_NGRP; g++) begin : g_grp
        tpo_group u_grp (
            .cur    (port_r[`TPO_GRP_POS(g) +: `TPO_GRP_W]),
            .staged (stg_r[`TPO_GRP_POS(g) +: `TPO_GRP_W]),
            .ev_a   (ev_a[g]),
            .ev_b   (ev_b[g]),
            .nov    (cfg_r.nonoverlap[`TPO_NOV_POS(g)]),
            .wr     (port_wr),
            .wdata  (port_wdata[`TPO_GRP_POS(g) +: `TPO_GRP_W]),
            .wmask  (wmask[`TPO_GRP_POS(g) +: `TPO_GRP_W]),
            .nxt    (port_nxt[`TPO_GRP_POS(g) +: `TPO_GRP_W])
        );
    end

    // Configuration and staged data next values
    always_comb begin
        cfg_nxt = cfg_r;
        cfg_seen_nxt = cfg_seen_r;
        stg_nxt = stg_r;
        if (cfg_wr) begin
            cfg_nxt = cfg_wdata;
            cfg_seen_nxt = 1'b1;
        end
        // Overwriting staged data inside the margin is the user's hazard
        if (staged_wr) begin
            stg_nxt = staged_wdata;
        end
    end

    // State registers; port data ignores pin claims on purpose
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cfg_r.port_direction <= `TPO_DIR_RST;
            cfg_r.next_enable    <= `TPO_EN_RST;
            cfg_r.trigger_select <= `TPO_SEL_RST;
            cfg_r.nonoverlap     <= `TPO_NOV_RST;
            cfg_seen_r           <= 1'b0;
            stg_r                <= `TPO_STG_RST;
            port_r               <= `TPO_PORT_RST;
            rd_r                 <= `TPO_RD_RST;
        end else begin
            cfg_r      <= cfg_nxt;
            cfg_seen_r <= cfg_seen_nxt;
            stg_r      <= stg_nxt;
            port_r     <= port_nxt;
            rd_r       <= rd_nxt;
        end
    end

    assign cfg          = cfg_r;
    assign staged_value = stg_r;
    assign port_value   = port_r;
    assign port_read    = rd_r;

    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    property p_claim_release;
        (pin_claimed & ~pin_oe_n) == '0;
    endproperty
    a_claim_release: assert property (p_claim_release)
        else $error("claimed pin is driven");

    property p_pin_shows_port;
        (cfg_r.next_enable[0] && cfg_r.port_direction[0] && !pin_claimed[0])
            |-> (!pin_oe_n[0] && pin_out[0] == port_value[0]);
    endproperty
    a_pin_shows_port: assert property (p_pin_shows_port)
        else $error("pattern pin not showing port data");

    property p_normal_copy;
        (ev_a[0] && !cfg_r.nonoverlap[0])
            |=> port_value[3:0] == $past(stg_r[3:0]);
    endproperty
    a_normal_copy: assert property (p_normal_copy)
        else $error("group 0 did not copy staged data");

    property p_nov_match_a;
        (ev_a[1] && cfg_r.nonoverlap[1])
            |=> port_value[7:4] == $past(stg_r[7:4]);
    endproperty
    a_nov_match_a: assert property (p_nov_match_a)
        else $error("match A did not copy all bits");

    property p_nov_match_b;
        (ev_b[0] && !ev_a[0] && !port_wr)
            |=> port_value[3:0] == ($past(port_r[3:0]) & $past(stg_r[3:0]));
    endproperty
    a_nov_match_b: assert property (p_nov_match_b)
        else $error("match B copied a one bit");

    property p_capture_trig;
        (cfg_r.trigger_select[1:0] == 2'h2 && timer_evt.capt_mode[2])
            |-> ev_a[0] == timer_evt.capt_a[2];
    endproperty
    a_capture_trig: assert property (p_capture_trig)
        else $error("capture did not replace match A");

    property p_sel_reset;
        !cfg_seen_r |-> cfg.trigger_select == `TPO_SEL_RST;
    endproperty
    a_sel_reset: assert property (p_sel_reset)
        else $error("trigger select lost its reset value");

    property p_locked_in;
        (port_wr && ev_a == '0 && ev_b == '0)
            |=> ((port_value ^ $past(port_r)) & $past(~wmask)) == '0;
    endproperty
    a_locked_in: assert property (p_locked_in)
        else $error("read-only port bit was written");

    property p_claimed_copy;
        (ev_a[2] && pin_claimed[8] && !cfg_r.nonoverlap[2])
            |=> port_value[8] == $past(stg_r[8]);
    endproperty
    a_claimed_copy: assert property (p_claimed_copy)
        else $error("claimed pin skipped transfer");

    property p_group_indep;
        (!ev_a[1] && !ev_b[1] && !port_wr) ##1 (!ev_a[1] && !ev_b[1])
            |-> $stable(port_value[7:4]);
    endproperty
    a_group_indep: assert property (p_group_indep)
        else $error("group 1 changed without its trigger");

    c_normal: cover property (ev_a[0] && !cfg_r.nonoverlap[0]);
    c_nov_b: cover property (ev_b[1] ##[1:20] ev_a[1]);
    c_capture: cover property (timer_evt.capt_mode[3] && ev_a[2]);
    c_claimed: cover property (ev_a[0] && pin_claimed[0]);

endmodule

/* File: tpo_timer_model.sv */
`timescale 1ns/1ps
`include "tpo_defs.svh"

// Behavioural timer that turns per-channel hits into one-cycle events
module tpo_timer_model (
    // Clock and reset
    input  wire logic                  clk_sys,
    input  wire logic                  rst_n,
    // Hit requests per channel from the bench
    input  wire logic [`TPO_NCH-1:0]   hit_a,
    input  wire logic [`TPO_NCH-1:0]   hit_b,
    input  wire logic [`TPO_NCH-1:0]   capt_mode,
    // Events toward the pattern unit
    output tpo_pkg::tpo_evt_s          evt
);
    // A register A hit is a capture or a compare, never both at once
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            evt <= '0;
        end else begin
            evt.cmp_a     <= hit_a & ~capt_mode;
            evt.capt_a    <= hit_a & capt_mode;
            evt.cmp_b     <= hit_b;
            evt.capt_mode <= capt_mode;
        end
    end
endmodule

/* File: tpo_tb.sv */
`timescale 1ns/1ps
`include "tpo_defs.svh"

`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin miscompares++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end

module tb;
    logic                    clk_sys = 1'b0;
    logic                    rst_n = 1'b0;
    logic                    cfg_wr = 1'b0;
    tpo_pkg::tpo_cfg_s       cfg_wdata = '0;
    tpo_pkg::tpo_cfg_s       cfg;
    logic                    staged_wr = 1'b0;
    logic [`TPO_NBITS-1:0]   staged_wdata = '0;
    logic                    port_wr = 1'b0;
    logic [`TPO_NBITS-1:0]   port_wdata = '0;
    tpo_pkg::tpo_evt_s       timer_evt;
    logic [`TPO_NBITS-1:0]   pin_claimed = '0;
    logic [`TPO_NBITS-1:0]   pin_in = '0;
    logic [`TPO_NBITS-1:0]   pin_out;
    logic [`TPO_NBITS-1:0]   pin_oe_n;
    logic [`TPO_NBITS-1:0]   staged_value;
    logic [`TPO_NBITS-1:0]   port_value;
    logic [`TPO_NBITS-1:0]   port_read;
    logic [`TPO_NCH-1:0]     hit_a = '0;
    logic [`TPO_NCH-1:0]     hit_b = '0;
    logic [`TPO_NCH-1:0]     capt_mode = '0;
    tpo_pkg::tpo_cfg_s       cfg_m;
    logic [`TPO_NBITS-1:0]   stg_m;
    logic [`TPO_NBITS-1:0]   port_m;
    logic [`TPO_NBITS-1:0]   read_m;
    logic [`TPO_NCH-1:0]     pend = '0;
    int                      miscompares = 0;
    int                      comparisons = 0;
    int                      cycles = 0;

    // Clock at 25 MHz
    always #20 clk_sys = ~clk_sys;

    tpo_timed_pattern dut (
        .clk_sys(clk_sys), .rst_n(rst_n), .cfg_wr(cfg_wr),
        .cfg_wdata(cfg_wdata), .cfg(cfg), .staged_wr(staged_wr),
        .staged_wdata(staged_wdata), .port_wr(port_wr),
        .port_wdata(port_wdata), .timer_evt(timer_evt),
        .pin_claimed(pin_claimed), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe_n(pin_oe_n), .staged_value(staged_value),
        .port_value(port_value), .port_read(port_read)
    );

    tpo_timer_model timer (
        .clk_sys(clk_sys), .rst_n(rst_n), .hit_a(hit_a), .hit_b(hit_b),
        .capt_mode(capt_mode), .evt(timer_evt)
    );

    // Next port data: software write, then each group's trigger on top
    function automatic logic [11:0] exp_port(tpo_pkg::tpo_cfg_s c,
        tpo_pkg::tpo_evt_s e, logic [11:0] cur, logic [11:0] stg,
        logic wr, logic [11:0] wd);
        logic [11:0] m;
        logic [11:0] r;
        logic [1:0]  ch;
        m = c.next_enable & ~c.port_direction;
        r = wr ? ((wd & ~m) | (cur & m)) : cur;
        for (int g = 0; g < 3; g++) begin
            ch = c.trigger_select[2*g +: 2];
            if (e.capt_mode[ch] ? e.capt_a[ch] : e.cmp_a[ch])
                r[4*g +: 4] = stg[4*g +: 4];
            else if (c.nonoverlap[g] && e.cmp_b[ch])
                r[4*g +: 4] = r[4*g +: 4] & stg[4*g +: 4];
        end
        return r;
    endfunction

    // Reference model, kept in step with the design on every edge
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cfg_m   <= '{`TPO_DIR_RST, `TPO_EN_RST, `TPO_SEL_RST, `TPO_NOV_RST};
            stg_m   <= `TPO_STG_RST;
            port_m  <= `TPO_PORT_RST;
            read_m  <= `TPO_RD_RST;
        end else begin
            port_m  <= exp_port(cfg_m, timer_evt, port_m, stg_m, port_wr,
                                port_wdata);
            // Inputs read the pin, outputs read back the port data
            read_m  <= (pin_in & ~cfg_m.port_direction)
                       | (port_m & cfg_m.port_direction);
            if (cfg_wr)
                cfg_m <= cfg_wdata;
            if (staged_wr)
                stg_m <= staged_wdata;
        end
    end

    // Hang guard, well above the planned run length
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 8000) begin
            miscompares++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        if (miscompares == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Check settled outputs, then drive one cycle of stimulus
    task automatic step(int n, logic [3:0] force_hit, int wr_odds);
        repeat (n) begin
            @(negedge clk_sys);
            `CHK(cfg, cfg_m)
            `CHK(staged_value, stg_m)
            `CHK(port_value, port_m)
            `CHK(pin_out, port_m)
            `CHK(pin_oe_n, ~(cfg_m.port_direction & ~pin_claimed))
            `CHK(port_read, read_m)
            // Pin functions change only after a trigger-free cycle
            cfg_wr       = (hit_a | hit_b) == '0
                           && ($urandom % wr_odds) == 0;
            hit_a        = cfg_wr ? 4'h0 : (4'($urandom) & 4'($urandom)) | force_hit;
            hit_b        = cfg_wr ? 4'h0 : 4'($urandom) & 4'($urandom);
            cfg_wdata    = tpo_pkg::tpo_cfg_s'({1'($urandom), $urandom});
            if (cfg_wr)
                capt_mode = 4'($urandom);
            // No staged writes from a match B until its match A has passed
            staged_wr    = (pend | hit_b) == '0
                           && $urandom % 2 == 0;
            pend         = (pend | hit_b) & ~hit_a;
            staged_wdata = 12'($urandom);
            port_wr      = $urandom % 4 == 0;
            port_wdata   = 12'($urandom);
            pin_claimed  = 12'($urandom) & 12'($urandom);
            pin_in       = 12'($urandom);
        end
    endtask

    // Reset, idle reset values, bursts, random traffic, mid-run reset
    initial begin
        void'($urandom(53677));
        repeat (3) @(negedge clk_sys);
        rst_n = 1'b1;
        step(4, 4'h0, 1000000);
        step(8, 4'hF, 2);
        step(3000, 4'h0, 16);
        @(negedge clk_sys);
        rst_n = 1'b0;
        step(2, 4'h0, 1000000);
        rst_n = 1'b1;
        step(2000, 4'h0, 8);
        report_and_stop();
    end
endmodule
